/* File: hdl/field_fifo_pkg.sv */
/*
  Shared constants and types for the serial field memory block: array
  geometry, old/new field spacing limits, pin bundle and write entry.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package field_fifo_pkg;
    // Array geometry
    localparam int DEPTH        = 262263;   // Words in the field array
    localparam int ADDR_W       = 19;       // Address counter width; 18 bits cannot reach the last word
    localparam int DATA_W       = 4;        // Word width
    // Old/new field spacing, in write-clock edges after the write reset
    localparam int OLD_LIMIT    = 119;      // Below this a read reset still gets the old field
    localparam int NEW_MIN      = 600;      // From this a read reset gets the new field
    localparam int GAP_W        = 10;       // Saturating gap counter width
    // Old-field shadow covering the start of a field
    localparam int SHADOW_DEPTH = 128;
    localparam int SHADOW_W     = 7;
    // Write staging buffer
    localparam int BUF_DEPTH    = 8;
    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;
    localparam logic [DATA_W-1:0] DATA_RESET = 4'h0;
    localparam logic [GAP_W-1:0]  GAP_RESET  = 10'h000;

    // Pin levels, synchronised together so data stays aligned with its clock
    typedef struct packed {
        logic              wclk;     // serial_write_clock
        logic              rclk;     // serial_read_clock
        logic              wrst;     // write_pointer_reset_strobe
        logic              rrst;     // read_pointer_reset_strobe
        logic              wgate;    // write_advance_gate
        logic              wmask;    // write_mask_gate
        logic              rgate;    // read_advance_gate
        logic              odrive;   // output_drive_gate
        logic [DATA_W-1:0] din;      // data input
    } pin_bus_t;

    // One staged write
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } wr_entry_t;

    // Array commit sequencer
    typedef enum {DRAIN_IDLE, DRAIN_COMMIT} drain_state_t;
endpackage
`default_nettype wire

/* File: hdl/stage_fifo.sv */
/*
  Small synchronous FIFO with valid/ready on both sides; width and depth
  are parameters. Assumes one clock and an active-low async reset.
*/
`timescale 1ns/10ps
`default_nettype none
module stage_fifo #(
    parameter int WIDTH = 23,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];     // Word storage
    logic [PW-1:0]    head_reg;          // Next slot to read
    logic [PW-1:0]    tail_reg;          // Next slot to write
    logic [PW:0]      count_reg;         // Words held
    wire              do_push;
    wire              do_pop;

    // Honest full and empty from the occupancy count
    // Count is one bit wider than the pointers, so full is compared at that width
    assign in_ready  = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = store[head_reg];
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;

    // Pointer and count bookkeeping
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            head_reg  <= '0;
            tail_reg  <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (do_push)
                tail_reg <= (tail_reg == PW'(DEPTH-1)) ? '0 : tail_reg + 1'b1;
            if (do_pop)
                head_reg <= (head_reg == PW'(DEPTH-1)) ? '0 : head_reg + 1'b1;
            count_reg <= count_reg + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end
    end

    // Storage has no reset; content is qualified by the count
    always_ff @(posedge sys_clk)
    begin
        if (do_push)
            store[tail_reg] <= in_data;
    end
endmodule
`default_nettype wire

/* File: hdl/field_memory.sv */
/*
  Serial field memory: write and read pointers stepped by pin clocks,
  write staging buffer, field array and old-field shadow.
  Assumes all pins are asynchronous to sys_clk and much slower than it.
*/
// Contract
// RULE1 - Controller re-runs reset, 130 clocks, reset
// RULE2 - Controller keeps 600 writes before read-back
// RULE3 - Read before next write reset: latest data
// RULE4 - Read reset under 119 edges: old field
// RULE5 - Read reset 600 after write: new field
// RULE6 - Gap 119 to 599 gives undefined data
// RULE7 - Writes stored correctly at any read lag
// RULE8 - Controller keeps read 600 behind write
// RULE9 - Devices chain output to input directly
// RULE10 - Write reset edge clears write pointer
// RULE11 - Read reset edge clears read pointer
// RULE12 - Advance gate holds pointer; mask skips store
// RULE13 - Drive gate off tristates; pointer still advances
// RULE14 - Dual-port 4-bit array, wrapping pointers
`timescale 1ns/10ps
`default_nettype none
module field_memory (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Write port pins
    input  wire logic        serial_write_clock,
    input  wire logic        write_pointer_reset_strobe,
    input  wire logic        write_advance_gate,
    input  wire logic        write_mask_gate,
    input  wire logic [3:0]  data_in,
    // Read port pins
    input  wire logic        serial_read_clock,
    input  wire logic        read_pointer_reset_strobe,
    input  wire logic        read_advance_gate,
    input  wire logic        output_drive_gate,
    output logic      [3:0]  data_out,
    output logic             data_out_en_n,
    // Staging status
    output logic             write_buffer_ready
);
    // Three-stage pin synchroniser
    field_fifo_pkg::pin_bus_t pin_in;
    field_fifo_pkg::pin_bus_t sync1_reg, sync2_reg, sync3_reg;
    logic wclk_lvl_reg;                  // Accepted write clock level
    logic rclk_lvl_reg;                  // Accepted read clock level

    assign pin_in = '{wclk: serial_write_clock, rclk: serial_read_clock,
                      wrst: write_pointer_reset_strobe, rrst: read_pointer_reset_strobe,
                      wgate: write_advance_gate, wmask: write_mask_gate,
                      rgate: read_advance_gate, odrive: output_drive_gate, din: data_in};

    // A level is accepted only once stages two and three agree
    function automatic logic settle(input logic s2, input logic s3, input logic prev);
        settle = (s2 == s3) ? s3 : prev;
    endfunction

    // Next address with wrap after the last word
    function automatic logic [field_fifo_pkg::ADDR_W-1:0] step(
        input logic [field_fifo_pkg::ADDR_W-1:0] a);
        step = (a == field_fifo_pkg::ADDR_W'(field_fifo_pkg::DEPTH-1)) ? '0 : a + 1'b1;
    endfunction

    wire wclk_next = settle(sync2_reg.wclk, sync3_reg.wclk, wclk_lvl_reg);
    wire rclk_next = settle(sync2_reg.rclk, sync3_reg.rclk, rclk_lvl_reg);
    wire w_edge    = wclk_next && !wclk_lvl_reg;
    wire r_edge    = rclk_next && !rclk_lvl_reg;

    // Synchroniser chain and accepted clock levels
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_reg    <= '0;
            sync2_reg    <= '0;
            sync3_reg    <= '0;
            wclk_lvl_reg <= 1'b0;
            rclk_lvl_reg <= 1'b0;
        end
        else
        begin
            sync1_reg    <= pin_in;
            sync2_reg    <= sync1_reg;
            sync3_reg    <= sync2_reg;
            wclk_lvl_reg <= wclk_next;
            rclk_lvl_reg <= rclk_next;
        end
    end

    // Write side decode; data and controls are taken from stage three
    logic [field_fifo_pkg::ADDR_W-1:0] wptr_reg;       // Write address counter
    logic [field_fifo_pkg::GAP_W-1:0]  gap_reg;        // Write edges since write reset
    wire w_reset   = w_edge && sync3_reg.wrst;
    wire w_advance = w_edge && !sync3_reg.wrst && sync3_reg.wgate;
    wire w_store   = w_advance && sync3_reg.wmask;
    wire gap_full  = (gap_reg == field_fifo_pkg::GAP_W'(field_fifo_pkg::NEW_MIN));

    // Write pointer and field gap counter
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wptr_reg <= field_fifo_pkg::ADDR_RESET;
            gap_reg  <= field_fifo_pkg::GAP_RESET;
        end
        else if (w_reset)
        begin
            wptr_reg <= field_fifo_pkg::ADDR_RESET;          // RULE10
            gap_reg  <= field_fifo_pkg::GAP_RESET;
        end
        else if (w_edge)
        begin
            if (w_advance)
                wptr_reg <= step(wptr_reg);                  // RULE12 RULE14
            if (!gap_full)
                gap_reg <= gap_reg + 1'b1;
        end
    end

    // Staging buffer; a full buffer drops the word but the pointer still steps
    field_fifo_pkg::wr_entry_t stage_in, stage_out;
    logic stage_valid;
    logic stage_pop;
    assign stage_in = '{addr: wptr_reg, data: sync3_reg.din};

    stage_fifo #(
        .WIDTH ($bits(field_fifo_pkg::wr_entry_t)),
        .DEPTH (field_fifo_pkg::BUF_DEPTH)
    ) u_stage (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .in_valid  (w_store),                                // RULE7
        .in_ready  (write_buffer_ready),
        .in_data   (stage_in),
        .out_valid (stage_valid),
        .out_ready (stage_pop),
        .out_data  (stage_out)
    );

    // Field array and the shadow that keeps the old field's first words
    logic [field_fifo_pkg::DATA_W-1:0] field_mem [field_fifo_pkg::DEPTH];
    logic [field_fifo_pkg::DATA_W-1:0] shadow_mem [field_fifo_pkg::SHADOW_DEPTH];
    logic [field_fifo_pkg::SHADOW_DEPTH-1:0] shadow_ok_reg;
    logic [field_fifo_pkg::DATA_W-1:0] old_word_reg;     // Word about to be overwritten
    logic [field_fifo_pkg::DATA_W-1:0] rd_word_reg;      // Array word at the read pointer
    field_fifo_pkg::wr_entry_t         commit_reg;       // Entry being committed
    field_fifo_pkg::drain_state_t      drain_reg;
    logic [field_fifo_pkg::ADDR_W-1:0] rptr_reg;         // Read address counter

    // Reads take the array's port in a read-edge cycle, so commits wait
    assign stage_pop = (drain_reg == field_fifo_pkg::DRAIN_IDLE) && stage_valid && !r_edge;
    wire in_shadow   = (commit_reg.addr < field_fifo_pkg::ADDR_W'(field_fifo_pkg::SHADOW_DEPTH));
    wire [field_fifo_pkg::SHADOW_W-1:0] c_idx = commit_reg.addr[field_fifo_pkg::SHADOW_W-1:0];
    wire save_old    = (drain_reg == field_fifo_pkg::DRAIN_COMMIT) && in_shadow && !shadow_ok_reg[c_idx];

    // Commit sequencer: fetch old word, then save it and write the new one
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            drain_reg <= field_fifo_pkg::DRAIN_IDLE;
        else
            case (drain_reg)
                field_fifo_pkg::DRAIN_IDLE:   drain_reg <= stage_pop ? field_fifo_pkg::DRAIN_COMMIT
                                                                     : field_fifo_pkg::DRAIN_IDLE;
                field_fifo_pkg::DRAIN_COMMIT: drain_reg <= field_fifo_pkg::DRAIN_IDLE;
                default:                      drain_reg <= field_fifo_pkg::DRAIN_IDLE;
            endcase
    end

    // Shadow validity: a save in the same cycle as a write reset wins
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            shadow_ok_reg <= '0;
        else
        begin
            for (int i = 0; i < field_fifo_pkg::SHADOW_DEPTH; i++)
                if (save_old && c_idx == field_fifo_pkg::SHADOW_W'(i))
                    shadow_ok_reg[i] <= 1'b1;                // RULE4
                else if (w_reset)
                    shadow_ok_reg[i] <= 1'b0;
        end
    end

    // Array ports; storage itself needs no reset
    always_ff @(posedge sys_clk)
    begin
        if (stage_pop)
        begin
            commit_reg   <= stage_out;
            old_word_reg <= field_mem[stage_out.addr];
        end
        if (drain_reg == field_fifo_pkg::DRAIN_COMMIT)
            field_mem[commit_reg.addr] <= commit_reg.data;   // RULE14
        if (save_old)
            shadow_mem[c_idx] <= old_word_reg;
        rd_word_reg <= field_mem[rptr_reg];
    end

    // Read side
    logic                              old_mode_reg;   // This read field serves old data
    wire r_reset   = r_edge && sync3_reg.rrst;
    wire r_advance = r_edge && !sync3_reg.rrst && sync3_reg.rgate;
    wire [field_fifo_pkg::SHADOW_W-1:0] r_idx = rptr_reg[field_fifo_pkg::SHADOW_W-1:0];
    wire use_shadow = old_mode_reg && shadow_ok_reg[r_idx]
                      && (rptr_reg < field_fifo_pkg::ADDR_W'(field_fifo_pkg::SHADOW_DEPTH));
    wire [field_fifo_pkg::DATA_W-1:0] r_word = use_shadow ? shadow_mem[r_idx] : rd_word_reg;

    // Read pointer, field mode and output register; the gap at read reset picks old or new
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rptr_reg      <= field_fifo_pkg::ADDR_RESET;
            old_mode_reg  <= 1'b0;
            data_out      <= field_fifo_pkg::DATA_RESET;
            data_out_en_n <= 1'b1;
        end
        else
        begin
            if (r_reset)
            begin
                rptr_reg     <= field_fifo_pkg::ADDR_RESET;  // RULE11
                // Gaps of 119 to 599 read the array as it stands: old, new or mixed
                old_mode_reg <= (gap_reg < field_fifo_pkg::GAP_W'(field_fifo_pkg::OLD_LIMIT)); // RULE4 RULE5 RULE6 RULE3
            end
            else if (r_advance)
            begin
                rptr_reg <= step(rptr_reg);                  // RULE13 RULE14
                data_out <= r_word;                          // RULE9
            end
            // Drive gate change counts only once stages two and three agree
            data_out_en_n <= !settle(sync2_reg.odrive, sync3_reg.odrive, !data_out_en_n); // RULE13
        end
    end

    // Assertions
    property p_wreset_clears;
        @(posedge sys_clk) disable iff (!resetn)
        w_reset |=> (wptr_reg == '0);
    endproperty
    a_wreset_clears: assert property (p_wreset_clears) else $error("write reset did not clear pointer"); // RULE10

    property p_rreset_clears;
        @(posedge sys_clk) disable iff (!resetn)
        r_reset |=> (rptr_reg == '0);
    endproperty
    a_rreset_clears: assert property (p_rreset_clears) else $error("read reset did not clear pointer"); // RULE11

    property p_wgate_hold;
        @(posedge sys_clk) disable iff (!resetn)
        (w_edge && !sync3_reg.wrst && !sync3_reg.wgate) |=> $stable(wptr_reg);
    endproperty
    a_wgate_hold: assert property (p_wgate_hold) else $error("write pointer moved with gate low"); // RULE12

    property p_mask_steps;
        @(posedge sys_clk) disable iff (!resetn)
        (w_advance && !sync3_reg.wmask) |=> (wptr_reg == step($past(wptr_reg))) && !$past(w_store);
    endproperty
    a_mask_steps: assert property (p_mask_steps) else $error("masked write mishandled"); // RULE12

    property p_read_steps;
        @(posedge sys_clk) disable iff (!resetn)
        (r_edge && !sync3_reg.rrst) |=> (rptr_reg == ($past(sync3_reg.rgate) ? step($past(rptr_reg))
                                                                           : $past(rptr_reg)));
    endproperty
    a_read_steps: assert property (p_read_steps) else $error("read pointer step wrong"); // RULE13

    property p_drive_off;
        @(posedge sys_clk) disable iff (!resetn)
        !sync3_reg.odrive ##1 !sync3_reg.odrive |-> data_out_en_n;
    endproperty
    a_drive_off: assert property (p_drive_off) else $error("output driven with drive gate low"); // RULE13

    property p_old_select;
        @(posedge sys_clk) disable iff (!resetn)
        (r_reset && gap_reg < field_fifo_pkg::GAP_W'(field_fifo_pkg::OLD_LIMIT)) |=> old_mode_reg;
    endproperty
    a_old_select: assert property (p_old_select) else $error("old field not selected"); // RULE4

    property p_new_select;
        @(posedge sys_clk) disable iff (!resetn)
        (r_reset && gap_reg == field_fifo_pkg::GAP_W'(field_fifo_pkg::NEW_MIN)) |=> !old_mode_reg;
    endproperty
    a_new_select: assert property (p_new_select) else $error("new field not selected"); // RULE5

    property p_wrap;
        @(posedge sys_clk) disable iff (!resetn)
        (w_advance && wptr_reg == field_fifo_pkg::ADDR_W'(field_fifo_pkg::DEPTH-1)) |=> (wptr_reg == '0);
    endproperty
    a_wrap: assert property (p_wrap) else $error("write pointer did not wrap"); // RULE14

    property p_commit;
        @(posedge sys_clk) disable iff (!resetn)
        stage_pop |=> (drain_reg == field_fifo_pkg::DRAIN_COMMIT) ##1 (drain_reg == field_fifo_pkg::DRAIN_IDLE);
    endproperty
    a_commit: assert property (p_commit) else $error("commit sequence broken"); // RULE7

    c_old_read:  cover property (@(posedge sys_clk) disable iff (!resetn) r_advance && use_shadow);
    c_new_read:  cover property (@(posedge sys_clk) disable iff (!resetn) r_reset && gap_full);
    c_buf_full:  cover property (@(posedge sys_clk) disable iff (!resetn) w_store && !write_buffer_ready);
endmodule
`default_nettype wire

/* File: bench/video_ctrl_model.sv */
/*
  Controller model for the serial field memory: drives the write and
  read pins one edge at a time, paced from sys_clk falling edges.
  Assumes sys_clk at 100 MHz and the 3-flop pin synchronisers inside.
*/
`timescale 1ns/10ps
`default_nettype none
module video_ctrl_model (
    // Pacing clock
    input  wire logic       sys_clk,
    // Write port pins
    output logic            serial_write_clock,
    output logic            write_pointer_reset_strobe,
    output logic            write_advance_gate,
    output logic            write_mask_gate,
    output logic      [3:0] data_in,
    // Read port pins
    output logic            serial_read_clock,
    output logic            read_pointer_reset_strobe,
    output logic            read_advance_gate,
    output logic            output_drive_gate,
    // Read data as seen at the pins
    input  wire logic [3:0] data_out,
    input  wire logic       data_out_en_n
);
    // Pins idle low; the pin clocks stand still between edges
    initial
    begin
        serial_write_clock = 1'b0;
        write_pointer_reset_strobe = 1'b0;
        write_advance_gate = 1'b0;
        write_mask_gate = 1'b0;
        data_in = 4'h0;
        serial_read_clock = 1'b0;
        read_pointer_reset_strobe = 1'b0;
        read_advance_gate = 1'b0;
        output_drive_gate = 1'b0;
    end

    // Wait a number of falling sys_clk edges
    task automatic pace(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // One write edge; controls held 3 cycles before and 5 after the rise
    task automatic wr_edge(input logic rst, input logic gate, input logic mask, input logic [3:0] d);
        write_pointer_reset_strobe = rst;
        write_advance_gate = gate;
        write_mask_gate = mask;
        data_in = d;
        pace(3);
        serial_write_clock = 1'b1;
        pace(5);
        serial_write_clock = 1'b0;
        // Hold time over: show the inverse so a late sample cannot pass
        data_in = ~d;
        pace(3);
    endtask

    // One read edge; word is sampled once the design has settled
    task automatic rd_edge(input logic rst, input logic gate, input logic drive,
                           output logic [3:0] q, output logic en_n);
        read_pointer_reset_strobe = rst;
        read_advance_gate = gate;
        output_drive_gate = drive;
        pace(3);
        serial_read_clock = 1'b1;
        pace(5);
        serial_read_clock = 1'b0;
        pace(3);
        q = data_out;
        en_n = data_out_en_n;
    endtask

    // Recovery start-up: reset, 130 clocks, reset on each port
    // Ports are never clocked together; read runs its 130 clocks while the write pointer stands still
    task automatic init_pointers;
        logic [3:0] q;
        logic       en_n;
        rd_edge(1'b1, 1'b0, 1'b0, q, en_n);
        repeat (130) rd_edge(1'b0, 1'b1, 1'b0, q, en_n);
        rd_edge(1'b1, 1'b0, 1'b0, q, en_n);
        wr_edge(1'b1, 1'b0, 1'b0, 4'h0);
        repeat (130) wr_edge(1'b0, 1'b1, 1'b0, 4'h0);
        wr_edge(1'b1, 1'b0, 1'b0, 4'h0);
    endtask
endmodule
`default_nettype wire

/* File: bench/field_memory_test.sv */
/*
  Self-checking bench for field_memory: field write/read-back, old and
  new field selection, gates and reset. Assumes video_ctrl_model.
*/
`timescale 1ns/10ps
`default_nettype none
module field_memory_test;
    // Clock, reset and pins
    logic       sys_clk;
    logic       resetn;
    logic       wclk, wrst, wgate, wmask, rclk, rrst, rgate, odrive;
    logic [3:0] din;
    logic [3:0] data_out;
    logic       en_n;
    logic       wbr;
    // Counters of the run
    int         bad_count;
    int         n_compared;
    // One write step: gate, mask, word, and what the array then holds
    typedef struct packed {logic gate; logic mask; logic [3:0] din; logic [3:0] exp;} wr_row_t;
    wr_row_t    rows [8];
    logic [3:0] exp_q [$];

    field_memory u_dut (.sys_clk(sys_clk), .resetn(resetn), .serial_write_clock(wclk),
        .write_pointer_reset_strobe(wrst), .write_advance_gate(wgate), .write_mask_gate(wmask),
        .data_in(din), .serial_read_clock(rclk), .read_pointer_reset_strobe(rrst),
        .read_advance_gate(rgate), .output_drive_gate(odrive), .data_out(data_out),
        .data_out_en_n(en_n), .write_buffer_ready(wbr));

    video_ctrl_model u_ctrl (.sys_clk(sys_clk), .serial_write_clock(wclk),
        .write_pointer_reset_strobe(wrst), .write_advance_gate(wgate), .write_mask_gate(wmask),
        .data_in(din), .serial_read_clock(rclk), .read_pointer_reset_strobe(rrst),
        .read_advance_gate(rgate), .output_drive_gate(odrive), .data_out(data_out),
        .data_out_en_n(en_n));

    // 100 MHz system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Compare and count
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic wrap_up;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog, about three and a half times the expected run of some 1600 edges
    initial
    begin
        #600000;
        bad_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        wrap_up();
    end

    // Main sequence
    initial
    begin
        int         p;
        logic [3:0] prev;
        logic [3:0] q;
        logic       e;
        bad_count = 0;
        n_compared = 0;
        resetn = 1'b0;
        prev = 4'h0;
        // Field B steps; masked steps keep field A's word (address low nibble)
        rows[0] = '{1'b1, 1'b1, 4'h3, 4'h3};
        rows[1] = '{1'b0, 1'b1, 4'h7, 4'h0};
        rows[2] = '{1'b1, 1'b0, 4'hc, 4'h1};
        rows[3] = '{1'b1, 1'b1, 4'ha, 4'ha};
        rows[4] = '{1'b0, 1'b0, 4'h5, 4'h0};
        rows[5] = '{1'b1, 1'b1, 4'h6, 4'h6};
        rows[6] = '{1'b1, 1'b0, 4'h0, 4'h4};
        rows[7] = '{1'b1, 1'b1, 4'hf, 4'hf};
        repeat (6) @(negedge sys_clk);
        check(data_out, 4'h0);
        check({3'h0, en_n}, 4'h1);
        check({3'h0, wbr}, 4'h1);
        resetn = 1'b1;
        $display("Test reset values done");

        // Field A: 640 words, more than 600 before any read-back
        u_ctrl.init_pointers();
        u_ctrl.wr_edge(1'b1, 1'b0, 1'b0, 4'h0);
        for (int k = 0; k < 640; k++)
            u_ctrl.wr_edge(1'b0, 1'b1, 1'b1, k[3:0]);
        // Read reset with gates low, then read with one gate and one drive gap
        u_ctrl.rd_edge(1'b1, 1'b0, 1'b0, q, e);
        p = 0;
        for (int k = 0; k < 16; k++)
        begin
            u_ctrl.rd_edge(1'b0, k != 9, k != 5, q, e);
            if (k != 9)
            begin
                prev = p[3:0];
                p++;
            end
            check(q, prev);
            check({3'h0, e}, {3'h0, k == 5});
        end
        $display("Test field A read-back done");

        // Field B from the row table
        u_ctrl.wr_edge(1'b1, 1'b0, 1'b0, 4'h0);
        foreach (rows[i])
        begin
            u_ctrl.wr_edge(1'b0, rows[i].gate, rows[i].mask, rows[i].din);
            if (rows[i].gate)
                exp_q.push_back(rows[i].exp);
        end
        // Read reset a few edges after write reset still yields field A
        u_ctrl.rd_edge(1'b1, 1'b0, 1'b1, q, e);
        for (int k = 0; k < 4; k++)
        begin
            u_ctrl.rd_edge(1'b0, 1'b1, 1'b1, q, e);
            check(q, k[3:0]);
        end
        $display("Test old field done");

        // Reading with a lag in the undefined span; data not judged
        repeat (200) u_ctrl.wr_edge(1'b0, 1'b1, 1'b1, 4'h9);
        u_ctrl.rd_edge(1'b1, 1'b0, 1'b1, q, e);
        repeat (2) u_ctrl.rd_edge(1'b0, 1'b1, 1'b1, q, e);
        repeat (420) u_ctrl.wr_edge(1'b0, 1'b1, 1'b1, 4'h9);
        // Read reset over 600 edges after write reset yields field B
        u_ctrl.rd_edge(1'b1, 1'b0, 1'b1, q, e);
        foreach (exp_q[i])
        begin
            u_ctrl.rd_edge(1'b0, 1'b1, 1'b1, q, e);
            check(q, exp_q[i]);
        end
        u_ctrl.rd_edge(1'b0, 1'b1, 1'b1, q, e);
        check(q, 4'h9);
        $display("Test new field done");

        // Reset in mid-run clears the read word and disables the drive
        resetn = 1'b0;
        repeat (2) @(negedge sys_clk);
        check(data_out, 4'h0);
        check({3'h0, en_n}, 4'h1);
        check({3'h0, wbr}, 4'h1);
        resetn = 1'b1;
        $display("Test mid-run reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
